// [rtl/iprb_top.sv]
// Bank of five interrupt priority registers behind an AHB-Lite slave.
//
// Overview of operation
// [R01] Field code 111 means level seven, highest.
// [R02] Field code 000 disables the source entirely.
// [R03] Field code 001 means level one, lowest.
// [R04] Codes two to six map linearly upward.
// [R05] Each field resets to binary 100.
// [R06] Bits 15, 11, 7, 3 read zero.
// [R07] Fields read back last written value.
// [R08] Register six: timer4, outcmp4, outcmp3, dma2.
// [R09] Register seven: uart2 tx, rx, ext2, timer5.
// [R10] Register eight: can1 event, rx, spi2 pair.
// [R11] Register nine: incap5, incap4, incap3, dma3.
// [R12] Register ten: outcmp7, outcmp6, outcmp5, incap6.
`timescale 1ns/1ps
module iprb_top
   import iprb_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [7:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic [2:0] timer4_level_out,
   output logic [2:0] outcmp4_level_out,
   output logic [2:0] outcmp3_level_out,
   output logic [2:0] dma_ch2_done_level_out,
   output logic [2:0] uart2_tx_level_out,
   output logic [2:0] uart2_rx_level_out,
   output logic [2:0] ext_irq2_level_out,
   output logic [2:0] timer5_level_out,
   output logic [2:0] can1_event_level_out,
   output logic [2:0] can1_rx_ready_level_out,
   output logic [2:0] spi2_event_level_out,
   output logic [2:0] spi2_error_level_out,
   output logic [2:0] incap5_level_out,
   output logic [2:0] incap4_level_out,
   output logic [2:0] incap3_level_out,
   output logic [2:0] dma_ch3_done_level_out,
   output logic [2:0] outcmp7_level_out,
   output logic [2:0] outcmp6_level_out,
   output logic [2:0] outcmp5_level_out,
   output logic [2:0] incap6_level_out,
   output logic [19:0] src_enable_out
);
   // Total number of sources served by the bank.
   localparam int NUM_SRC = IPRB_NUM_REGS * IPRB_FIELDS;

   // Register storage, indexed by register number 0 (six) to 4 (ten).
   logic [IPRB_REG_W-1:0] prio_reg [IPRB_NUM_REGS];
   // Data-phase state of the bus slave.
   iprb_state_t state;
   // Register index captured in the address phase.
   logic [2:0] dp_index;
   // High when the captured address hit a register.
   logic dp_hit;
   // Decoded index of the current address phase.
   logic [2:0] ap_index;
   // High when the current address phase names a register.
   logic ap_hit;
   // High when a valid transfer is presented to this slave.
   logic ap_valid;
   // Read word assembled from the addressed register.
   logic [31:0] next_rdata;

   // Link between register storage and the level decoder.
   iprb_lvl_if lvl ();

   // Decoder of field codes into levels and enables.
   iprb_level_dec #(
      .NUM_SRC(NUM_SRC)
   ) u_dec (
      .lvl(lvl)
   );

   // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready.
   // The transfer size is not looked at: every register is one whole word,
   // so a narrower access from software still writes the full field set.
   assign ap_valid = hsel_in && hready_in &&
                     (htrans_in == IPRB_HTRANS_NONSEQ || htrans_in == IPRB_HTRANS_SEQ);

   // Address decode: only the five word offsets are mapped.
   // Unaligned addresses fall to the default branch on purpose, so a stray
   // byte access can never alias onto a neighbouring register.
   always_comb begin
      ap_hit = 1'b1;
      case (haddr_in)
         IPRB_OFS_CTRL_6: begin
            ap_index = 3'h0;
         end
         IPRB_OFS_CTRL_7: begin
            ap_index = 3'h1;
         end
         IPRB_OFS_CTRL_8: begin
            ap_index = 3'h2;
         end
         IPRB_OFS_CTRL_9: begin
            ap_index = 3'h3;
         end
         IPRB_OFS_CTRL_10: begin
            ap_index = 3'h4;
         end
         default: begin
            // Unmapped addresses read zero and ignore writes.
            ap_index = 3'h0;
            ap_hit = 1'b0;
         end
      endcase
   end

   // Capture the address phase for use in the following data phase.
   // Write data arrives one cycle after its address, so the index and the
   // kind of transfer must be held across that cycle.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= IPRB_ST_IDLE;
         dp_index <= 3'h0;
         dp_hit <= 1'b0;
      end else begin
         if (ap_valid) begin
            dp_index <= ap_index;
            dp_hit <= ap_hit;
            state <= hwrite_in ? IPRB_ST_WRITE : IPRB_ST_READ;
         end else begin
            state <= IPRB_ST_IDLE;
         end
      end
   end

   // Register write, one process per register; the mask keeps bits
   // 15, 11, 7 and 3 at zero so no write can ever set them.
   // Storing the masked word means the absent bits need no flip-flops of
   // their own once synthesis trims the constant zeros.
   genvar gr;
   generate
      for (gr = 0; gr < IPRB_NUM_REGS; gr++) begin : g_reg
         always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               prio_reg[gr] <= IPRB_REG_RESET; // [R05]
            end else if (state == IPRB_ST_WRITE && dp_hit && dp_index == 3'(gr)) begin
               prio_reg[gr] <= hwdata_in[IPRB_REG_W-1:0] & IPRB_IMPL_MASK; // [R06] [R07]
            end
         end
         // Fields go to the decoder in register order, field 0 lowest.
         assign lvl.raw[gr*IPRB_REG_W-gr*4 +: 12] = {
            prio_reg[gr][IPRB_FLD_POS_3 +: IPRB_LVL_W],
            prio_reg[gr][IPRB_FLD_POS_2 +: IPRB_LVL_W],
            prio_reg[gr][IPRB_FLD_POS_1 +: IPRB_LVL_W],
            prio_reg[gr][IPRB_FLD_POS_0 +: IPRB_LVL_W]
         };
      end
   endgenerate

   // Read data for the address phase now on the bus. Fetching here and
   // registering it means hrdata is ready in the data phase with no wait,
   // at the cost of reflecting a write that finishes in the same cycle a
   // cycle late; the bypass below closes that gap.
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (ap_hit) begin
         if (state == IPRB_ST_WRITE && dp_hit && dp_index == ap_index) begin
            // Back-to-back write then read of one register sees the new value.
            next_rdata[IPRB_REG_W-1:0] = hwdata_in[IPRB_REG_W-1:0] & IPRB_IMPL_MASK; // [R07]
         end else begin
            next_rdata[IPRB_REG_W-1:0] = prio_reg[ap_index] & IPRB_IMPL_MASK; // [R06]
         end
      end
   end

   // Ready of the bus answer. It is low while reset is held, so a master
   // that starts at once after release simply waits one cycle; after that
   // the slave never inserts a wait state.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hreadyout_out <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
      end
   end

   // Response of the bus answer. Every transfer, mapped or not, ends OKAY;
   // an unmapped access is ignored rather than flagged as an error.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hresp_out <= 1'b0;
      end else begin
         hresp_out <= 1'b0;
      end
   end

   // Read data of the bus answer, loaded at the end of the address phase so
   // it stands for the whole data phase and is zero otherwise.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (ap_valid && !hwrite_in) begin
         // A read presents the addressed word with absent bits cleared. [R06]
         hrdata_out <= next_rdata;
      end else begin
         // Writes and idle cycles show zero, so stale data never lingers.
         hrdata_out <= 32'h0000_0000;
      end
   end

   // Levels of register six, registered so each port comes from a flip-flop.
   // The extra stage puts every level one cycle behind its stored field;
   // arbitration can afford that since priorities change only by software.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         timer4_level_out <= IPRB_LVL_RESET; // [R05]
         outcmp4_level_out <= IPRB_LVL_RESET;
         outcmp3_level_out <= IPRB_LVL_RESET;
         dma_ch2_done_level_out <= IPRB_LVL_RESET;
      end else begin
         // Field 3 down to field 0. [R08]
         timer4_level_out <= lvl.level[9 +: 3];
         outcmp4_level_out <= lvl.level[6 +: 3];
         outcmp3_level_out <= lvl.level[3 +: 3];
         dma_ch2_done_level_out <= lvl.level[0 +: 3];
      end
   end

   // Levels of register seven, field 3 down to field 0.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         // Every source starts at level four. [R05]
         uart2_tx_level_out <= IPRB_LVL_RESET;
         uart2_rx_level_out <= IPRB_LVL_RESET;
         ext_irq2_level_out <= IPRB_LVL_RESET;
         timer5_level_out <= IPRB_LVL_RESET;
      end else begin
         uart2_tx_level_out <= lvl.level[21 +: 3]; // [R09]
         uart2_rx_level_out <= lvl.level[18 +: 3];
         ext_irq2_level_out <= lvl.level[15 +: 3];
         timer5_level_out <= lvl.level[12 +: 3];
      end
   end

   // Levels of register eight, field 3 down to field 0.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         // Every source starts at level four. [R05]
         can1_event_level_out <= IPRB_LVL_RESET;
         can1_rx_ready_level_out <= IPRB_LVL_RESET;
         spi2_event_level_out <= IPRB_LVL_RESET;
         spi2_error_level_out <= IPRB_LVL_RESET;
      end else begin
         can1_event_level_out <= lvl.level[33 +: 3]; // [R10]
         can1_rx_ready_level_out <= lvl.level[30 +: 3];
         spi2_event_level_out <= lvl.level[27 +: 3];
         spi2_error_level_out <= lvl.level[24 +: 3];
      end
   end

   // Levels of register nine, field 3 down to field 0.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         // Every source starts at level four. [R05]
         incap5_level_out <= IPRB_LVL_RESET;
         incap4_level_out <= IPRB_LVL_RESET;
         incap3_level_out <= IPRB_LVL_RESET;
         dma_ch3_done_level_out <= IPRB_LVL_RESET;
      end else begin
         incap5_level_out <= lvl.level[45 +: 3]; // [R11]
         incap4_level_out <= lvl.level[42 +: 3];
         incap3_level_out <= lvl.level[39 +: 3];
         dma_ch3_done_level_out <= lvl.level[36 +: 3];
      end
   end

   // Levels of register ten, field 3 down to field 0.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         // Every source starts at level four. [R05]
         outcmp7_level_out <= IPRB_LVL_RESET;
         outcmp6_level_out <= IPRB_LVL_RESET;
         outcmp5_level_out <= IPRB_LVL_RESET;
         incap6_level_out <= IPRB_LVL_RESET;
      end else begin
         outcmp7_level_out <= lvl.level[57 +: 3]; // [R12]
         outcmp6_level_out <= lvl.level[54 +: 3];
         outcmp5_level_out <= lvl.level[51 +: 3];
         incap6_level_out <= lvl.level[48 +: 3];
      end
   end

   // Per-source enables, kept in step with the level ports above so that
   // arbitration never sees a level and an enable from different writes.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src_enable_out <= 20'hfffff;
      end else begin
         // A zero code drops the enable so the source never requests. [R02]
         src_enable_out <= lvl.enable;
      end
   end
endmodule

// [common/iprb_pkg.sv]
// Package of constants and types for the interrupt priority register bank.
package iprb_pkg;
   // Number of priority registers in the bank.
   localparam int IPRB_NUM_REGS = 5;
   // Number of priority fields held in each register.
   localparam int IPRB_FIELDS = 4;
   // Width of one priority field.
   localparam int IPRB_LVL_W = 3;
   // Implemented width of each register.
   localparam int IPRB_REG_W = 16;
   // Byte offsets of the five registers on the bus.
   localparam logic [7:0] IPRB_OFS_CTRL_6 = 8'h00;
   localparam logic [7:0] IPRB_OFS_CTRL_7 = 8'h04;
   localparam logic [7:0] IPRB_OFS_CTRL_8 = 8'h08;
   localparam logic [7:0] IPRB_OFS_CTRL_9 = 8'h0c;
   localparam logic [7:0] IPRB_OFS_CTRL_10 = 8'h10;
   // Low bit position of each field inside a register, field 0 lowest.
   localparam int IPRB_FLD_POS_0 = 0;
   localparam int IPRB_FLD_POS_1 = 4;
   localparam int IPRB_FLD_POS_2 = 8;
   localparam int IPRB_FLD_POS_3 = 12;
   // Mask of the implemented bits; bits 15, 11, 7 and 3 are absent.
   localparam logic [15:0] IPRB_IMPL_MASK = 16'h7777;
   // Power-on value of one field: upper bit set, lower bits clear.
   localparam logic [2:0] IPRB_LVL_RESET = 3'h4;
   // Power-on value of a whole register.
   localparam logic [15:0] IPRB_REG_RESET = 16'h4444;
   // Field code that disables a source.
   localparam logic [2:0] IPRB_LVL_OFF = 3'h0;
   // Field code of the lowest and highest enabled levels.
   localparam logic [2:0] IPRB_LVL_MIN = 3'h1;
   localparam logic [2:0] IPRB_LVL_MAX = 3'h7;
   // AHB transfer type codes used by the slave.
   localparam logic [1:0] IPRB_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] IPRB_HTRANS_SEQ = 2'h3;
   // Width of one word on the bus.
   localparam int IPRB_DATA_W = 32;
   // One-hot states of the bus data phase.
   typedef enum logic [2:0] {
      IPRB_ST_IDLE = 3'b001,
      IPRB_ST_WRITE = 3'b010,
      IPRB_ST_READ = 3'b100
   } iprb_state_t;
endpackage

// [common/iprb_lvl_if.sv]
// Interface carrying the stored fields to the level decoder and its results back.
`timescale 1ns/1ps
interface iprb_lvl_if;
   import iprb_pkg::*;
   // Raw field codes, twenty fields of three bits.
   logic [IPRB_NUM_REGS*IPRB_FIELDS*IPRB_LVL_W-1:0] raw;
   // Decoded priority levels presented to arbitration.
   logic [IPRB_NUM_REGS*IPRB_FIELDS*IPRB_LVL_W-1:0] level;
   // One bit per source, high when the source may request service.
   logic [IPRB_NUM_REGS*IPRB_FIELDS-1:0] enable;
   // The register file drives raw codes and reads the results.
   modport regs (output raw, input level, input enable);
   // The decoder reads raw codes and drives the results.
   modport dec (input raw, output level, output enable);
endinterface

// [rtl/iprb_level_dec.sv]
// Decoder turning stored priority field codes into arbitration levels.
`timescale 1ns/1ps
module iprb_level_dec
   import iprb_pkg::*;
#(
   parameter int NUM_SRC = IPRB_NUM_REGS * IPRB_FIELDS
) (
   iprb_lvl_if.dec lvl
);
   // One decoder slice per source; the mapping is the same for each.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
         logic [IPRB_LVL_W-1:0] code;
         assign code = lvl.raw[gi*IPRB_LVL_W +: IPRB_LVL_W];
         // Code 7 is level 7, the highest level. [R01]
         // Code 1 is level 1, the lowest enabled level. [R03]
         // Codes 2 to 6 pass straight through, so larger means higher. [R04]
         assign lvl.level[gi*IPRB_LVL_W +: IPRB_LVL_W] = code;
         // Code 0 disables the source so it never asks for service. [R02]
         assign lvl.enable[gi] = (code != IPRB_LVL_OFF);
      end
   endgenerate
endmodule

// [bench/iprb_properties.sv]
// Checker of the port behaviour of the priority register bank.
`timescale 1ns/1ps
module iprb_properties (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [7:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   input wire logic [31:0] hrdata_out,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic [2:0] timer4_level_out,
   input wire logic [2:0] dma_ch2_done_level_out,
   input wire logic [2:0] incap6_level_out,
   input wire logic [2:0] outcmp7_level_out,
   input wire logic [19:0] src_enable_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // High when an address phase is accepted (NONSEQ or SEQ).
   wire take = hsel_in && hready_in && htrans_in[1];
   // Written field reaches its level port three edges after acceptance.
   property p_wr(logic [7:0] a, logic [2:0] lvl, logic [2:0] dat);
      take && hwrite_in && haddr_in == a |-> ##3 lvl == $past(dat, 2);
   endproperty
   chk_wr_timer4: assert property (p_wr(8'h00, timer4_level_out, hwdata_in[14:12]))
      else $error("timer4 level does not follow write");
   chk_wr_dma2: assert property (p_wr(8'h00, dma_ch2_done_level_out, hwdata_in[2:0]))
      else $error("dma2 level does not follow write");
   chk_wr_outcmp7: assert property (p_wr(8'h10, outcmp7_level_out, hwdata_in[14:12]))
      else $error("outcmp7 level does not follow write");
   chk_wr_incap6: assert property (p_wr(8'h10, incap6_level_out, hwdata_in[2:0]))
      else $error("incap6 level does not follow write");
   chk_off_disables: assert property (src_enable_out[0] == (dma_ch2_done_level_out != 3'h0))
      else $error("enable disagrees with dma2 level");
   chk_low_enabled: assert property (outcmp7_level_out == 3'h1 |-> src_enable_out[19])
      else $error("level one source not enabled");
   chk_absent_bits: assert property ((hrdata_out & 32'hffff_8888) == 32'h0)
      else $error("absent bit reads as one");
   chk_unmapped_read: assert property (take && !hwrite_in && haddr_in > 8'h10 |=> hrdata_out == 0)
      else $error("unmapped read not zero");
   chk_reset_level: assert property (!$past(rst_n_in) |-> timer4_level_out == 3'h4 && &src_enable_out)
      else $error("power-on level not four");
   chk_ready_okay: assert property ($past(rst_n_in) |-> hreadyout_out && !hresp_out)
      else $error("slave stalled or answered error");
   cov_write_reg6: cover property (take && hwrite_in && haddr_in == 8'h00);
   cov_unmapped: cover property (take && !hwrite_in && haddr_in > 8'h10);
   cov_top_level: cover property (outcmp7_level_out == 3'h7);
endmodule
bind iprb_top iprb_properties u_chk (.*);

// [bench/tb.sv]
// Self-checking bench for the priority register bank.
`timescale 1ns/1ps
module tb;
   import iprb_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic hsel_in = 1'b0;
   logic [7:0] haddr_in = 8'h00;
   logic [1:0] htrans_in = 2'h0;
   logic hwrite_in = 1'b0;
   logic [2:0] hsize_in = 3'h2; // Always whole words.
   logic hready_in;
   logic [31:0] hwdata_in = 32'h0;
   logic [31:0] hrdata_out;
   logic hreadyout_out, hresp_out;
   logic [2:0] timer4_level_out, outcmp4_level_out, outcmp3_level_out, dma_ch2_done_level_out;
   logic [2:0] uart2_tx_level_out, uart2_rx_level_out, ext_irq2_level_out, timer5_level_out;
   logic [2:0] can1_event_level_out, can1_rx_ready_level_out, spi2_event_level_out;
   logic [2:0] spi2_error_level_out, incap5_level_out, incap4_level_out, incap3_level_out;
   logic [2:0] dma_ch3_done_level_out, outcmp7_level_out, outcmp6_level_out, outcmp5_level_out;
   logic [2:0] incap6_level_out;
   logic [19:0] src_enable_out;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   logic [15:0] exp_reg [IPRB_NUM_REGS]; // Expected contents of each register.
   logic [59:0] lvl_all; // Level ports, register-major, field 0 lowest.
   // With one slave its ready is the bus ready.
   assign hready_in = hreadyout_out;
   assign lvl_all = {outcmp7_level_out, outcmp6_level_out, outcmp5_level_out, incap6_level_out,
      incap5_level_out, incap4_level_out, incap3_level_out, dma_ch3_done_level_out,
      can1_event_level_out, can1_rx_ready_level_out, spi2_event_level_out, spi2_error_level_out,
      uart2_tx_level_out, uart2_rx_level_out, ext_irq2_level_out, timer5_level_out,
      timer4_level_out, outcmp4_level_out, outcmp3_level_out, dma_ch2_done_level_out};
   iprb_top u_iprb_top (.*);
   // Clock of 8 ns period.
   initial begin
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   // A hung handshake ends the run as a failure.
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         end_sim();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Waits for ready sampled high at a rising edge and takes the answer there.
   task automatic wait_ready(output logic [31:0] q);
      @(posedge clk_sys_in);
      while (hreadyout_out !== 1'b1) @(posedge clk_sys_in);
      q = hrdata_out;
      check(32'(hresp_out), 32'h0);
   endtask
   // One single transfer; entered right after a rising edge.
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d,
      output logic [31:0] q);
      hsel_in <= 1'b1;
      htrans_in <= IPRB_HTRANS_NONSEQ;
      haddr_in <= a;
      hwrite_in <= wr;
      wait_ready(q);
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= d;
      wait_ready(q);
   endtask
   task automatic do_reset();
      rst_n_in <= 1'b0;
      repeat (5) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      for (int i = 0; i < IPRB_NUM_REGS; i++) exp_reg[i] = IPRB_REG_RESET;
   endtask
   // Reads every register, then compares its level ports and enables.
   task automatic check_all();
      logic [31:0] q;
      logic [2:0] f;
      for (int i = 0; i < IPRB_NUM_REGS; i++) begin
         bus(8'(i * 4), 1'b0, 32'h0, q);
         check(q, {16'h0, exp_reg[i]});
         for (int j = 0; j < IPRB_FIELDS; j++) begin
            f = exp_reg[i][j * 4 +: 3];
            check(32'(lvl_all[(i * 4 + j) * 3 +: 3]), 32'(f));
            check(32'(src_enable_out[i * 4 + j]), 32'(f != 3'h0));
         end
      end
   endtask
   // Sweeps every code through every field, absent bits written as ones.
   task automatic t_fields();
      logic [31:0] q;
      logic [15:0] w;
      for (int c = 0; c < 8; c++) begin
         for (int i = 0; i < IPRB_NUM_REGS; i++) begin
            for (int j = 0; j < IPRB_FIELDS; j++) w[j * 4 +: 4] = {1'b1, 3'(c + i + j)};
            exp_reg[i] = w & IPRB_IMPL_MASK;
            bus(8'(i * 4), 1'b1, {16'hffff, w}, q);
         end
         check_all();
      end
   endtask
   // Writes outside the bank must change nothing and read back zero.
   task automatic t_unmapped();
      logic [31:0] q;
      bus(8'h14, 1'b1, 32'hffff_ffff, q);
      bus(8'hfc, 1'b1, 32'h0, q);
      bus(8'h14, 1'b0, 32'h0, q);
      check(q, 32'h0);
      check_all();
   endtask
   initial begin
      do_reset();
      check_all();
      t_fields();
      t_unmapped();
      do_reset();
      check_all();
      end_sim();
   end
endmodule
